// File: core/ump_mproc_rx.v
`timescale 1ns/100ps
`include "ump_defs.vh"
module ump_mproc_rx #(
  parameter BIT_CLKS = `UMP_BIT_CLKS
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd,
  output reg irq
);
  reg [7:0] mp_ctl;
  reg [7:0] mode;
  reg [8:0] rx_buf;
  reg rx_complete_flag;
  reg overrun_error_flag;
  reg framing_error_flag;
  reg parity_error_flag;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg rxd_m;
  reg rxd_s;
  wire frame_done;
  wire [7:0] frame_data;
  wire frame_ninth;
  wire frame_stop_bad;

  // Decode helpers, shared by read and write paths
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  function known;
    input [11:0] a;
    begin
      known = hit(a, `UMP_ADDR_MPCTL) || hit(a, `UMP_ADDR_MODE) ||
              hit(a, `UMP_ADDR_RXBUF) || hit(a, `UMP_ADDR_STAT) ||
              hit(a, `UMP_ADDR_IRQST) || hit(a, `UMP_ADDR_IRQMSK);
    end
  endfunction

  wire mproc_enable = mp_ctl[`UMP_BIT_MPEN];
  wire wait_for_address_frame = mp_ctl[`UMP_BIT_WAIT];
  wire [2:0] serial_mode_select = mode[`UMP_POS_SMD+2:`UMP_POS_SMD];
  wire parity_enable = mode[`UMP_BIT_PAR_EN];
  wire parity_odd_even_select = mode[`UMP_BIT_PAR_ODD];
  wire rx_en = mode[`UMP_BIT_RX_EN] &&
               (serial_mode_select != `UMP_SMD_OFF);
  // Wait state only counts while multiprocessor mode is on
  wire filtering = mproc_enable && wait_for_address_frame;
  // Parity settings ignored in multiprocessor mode
  wire par_on = parity_enable && !mproc_enable;
  wire ninth_en = mproc_enable || par_on;

  // Two-stage synchroniser on the serial pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
    end else if (clk_en) begin
      rxd_m <= rxd;
      rxd_s <= rxd_m;
    end
  end

  ump_rx_frame #(
    .BIT_CLKS(BIT_CLKS)
  ) u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .rx_enable(rx_en),
    .ninth_en(ninth_en),
    .rxd_sync(rxd_s),
    .frame_done(frame_done),
    .frame_data(frame_data),
    .frame_ninth(frame_ninth),
    .frame_stop_bad(frame_stop_bad)
  );

  // Frame classification
  wire drop = filtering && !frame_ninth;
  wire accept = frame_done && !drop;
  wire addr_hit = frame_done && filtering && frame_ninth;
  wire par_bad = par_on &&
                 (^{frame_data, frame_ninth, parity_odd_even_select});

  // APB access strobes; zero-wait slave
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire rd_buf = rd && hit(paddr, `UMP_ADDR_RXBUF);
  wire wr_ist = wr && hit(paddr, `UMP_ADDR_IRQST);

  // Control registers; hardware clear of the wait bit beats a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp_ctl <= `UMP_RST_MPCTL;
      mode <= `UMP_RST_MODE;
      irq_mask <= 3'h0;
    end else if (clk_en) begin
      if (wr && hit(paddr, `UMP_ADDR_MPCTL)) begin
        // Only b0, b4 and b7 store; b7 is a write-zero reserved bit
        mp_ctl <= pwdata[7:0] & 8'h91;
      end
      if (wr && hit(paddr, `UMP_ADDR_MODE))
        mode <= pwdata[7:0];
      if (wr && hit(paddr, `UMP_ADDR_IRQMSK))
        irq_mask <= pwdata[2:0];
      if (addr_hit)
        mp_ctl[`UMP_BIT_WAIT] <= 1'b0;
    end
  end

  // Receive buffer and flags; a new frame wins over a read clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf <= 9'h000;
      rx_complete_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (!rx_en) begin
        // Errors cleared while the receiver is off
        rx_complete_flag <= 1'b0;
        overrun_error_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag <= 1'b0;
      end else if (accept) begin
        rx_buf <= {frame_ninth, frame_data};
        rx_complete_flag <= 1'b1;
        overrun_error_flag <= rx_complete_flag && !rd_buf;
        framing_error_flag <= frame_stop_bad;
        parity_error_flag <= par_bad;
      end else if (rd_buf) begin
        rx_complete_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear; set wins
  wire [2:0] ev = {addr_hit, accept && (frame_stop_bad || par_bad ||
                   (rx_complete_flag && !rd_buf)), accept};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat <= 3'h0;
    else if (clk_en)
      irq_stat <= (irq_stat & ~(wr_ist ? pwdata[2:0] : 3'h0)) | ev;
  end

  // Read mux; unmapped addresses return zero with an error
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, `UMP_ADDR_MPCTL))
      next_prdata = {24'h000000, mp_ctl & 8'h11};
    else if (hit(paddr, `UMP_ADDR_MODE))
      next_prdata = {24'h000000, mode};
    else if (hit(paddr, `UMP_ADDR_RXBUF))
      next_prdata = {23'h000000, rx_buf};
    else if (hit(paddr, `UMP_ADDR_STAT))
      next_prdata = {27'h0000000, overrun_error_flag |
                     framing_error_flag | parity_error_flag,
                     parity_error_flag, framing_error_flag,
                     overrun_error_flag, rx_complete_flag};
    else if (hit(paddr, `UMP_ADDR_IRQST))
      next_prdata = {29'h00000000, irq_stat};
    else if (hit(paddr, `UMP_ADDR_IRQMSK))
      next_prdata = {29'h00000000, irq_mask};
  end

  // APB outputs registered: answer in the first cycle of the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known(paddr);
      if (psel && !penable)
        prdata <= next_prdata;
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // ump_mproc_rx

// File: core/ump_defs.vh
`ifndef UMP_DEFS_VH
`define UMP_DEFS_VH
// Register byte addresses on APB; the control register index is a word index
`define UMP_IDX_MPCTL 8'hBB
`define UMP_ADDR_MPCTL 12'h2EC
`define UMP_ADDR_MODE 12'h000
`define UMP_ADDR_RXBUF 12'h004
`define UMP_ADDR_STAT 12'h008
`define UMP_ADDR_IRQST 12'h00C
`define UMP_ADDR_IRQMSK 12'h010
// Field positions in the multiprocessor control register
`define UMP_BIT_MPEN 0
`define UMP_BIT_WAIT 4
`define UMP_BIT_RSVD7 7
// Field positions in the mode register
`define UMP_BIT_PAR_EN 0
`define UMP_BIT_PAR_ODD 1
`define UMP_BIT_RX_EN 2
`define UMP_POS_SMD 4
// Field positions in the receive status register
`define UMP_BIT_RXC 0
`define UMP_BIT_OVR 1
`define UMP_BIT_FRM 2
`define UMP_BIT_PAR 3
`define UMP_BIT_SUM 4
// Interrupt status bits
`define UMP_IRQ_RXC 0
`define UMP_IRQ_ERR 1
`define UMP_IRQ_ADDR 2
// Reset values
`define UMP_RST_MPCTL 8'h00
`define UMP_RST_MODE 8'h00
// Serial mode encodings
`define UMP_SMD_OFF 3'h0
`define UMP_SMD_SYNC 3'h1
// Oversampling of the serial line, clocks per bit
`define UMP_BIT_CLKS 16
`endif

// File: core/ump_rx_frame.v
`timescale 1ns/100ps
// Asynchronous frame receiver: start, 8 data, optional ninth bit, stop
module ump_rx_frame #(
  parameter BIT_CLKS = 16
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire rx_enable,
  input wire ninth_en,
  input wire rxd_sync,
  output reg frame_done,
  output reg [7:0] frame_data,
  output reg frame_ninth,
  output reg frame_stop_bad
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS = 2'h2;
  localparam ST_STOP = 2'h3;
  localparam CW = 8;

  reg [1:0] state;
  reg [CW-1:0] tick;
  reg [3:0] nbit;
  reg [8:0] shift;

  // Sample at mid bit; the ninth bit sits where parity would be
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      tick <= 8'h00;
      nbit <= 4'h0;
      shift <= 9'h000;
      frame_done <= 1'b0;
      frame_data <= 8'h00;
      frame_ninth <= 1'b0;
      frame_stop_bad <= 1'b0;
    end else if (clk_en) begin
      frame_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          tick <= 8'h00;
          if (rx_enable && !rxd_sync)
            state <= ST_START;
        end
        ST_START: begin
          if (tick == BIT_CLKS/2 - 1) begin
            tick <= 8'h00;
            nbit <= 4'h0;
            state <= rxd_sync ? ST_IDLE : ST_BITS; // Glitch rejected
          end else
            tick <= tick + 8'h01;
        end
        ST_BITS: begin
          if (tick == BIT_CLKS - 1) begin
            tick <= 8'h00;
            shift <= {rxd_sync, shift[8:1]};
            nbit <= nbit + 4'h1;
            if (nbit == (ninth_en ? 4'h8 : 4'h7))
              state <= ST_STOP;
          end else
            tick <= tick + 8'h01;
        end
        ST_STOP: begin
          if (tick == BIT_CLKS - 1) begin
            tick <= 8'h00;
            state <= ST_IDLE;
            frame_done <= 1'b1;
            frame_stop_bad <= !rxd_sync;
            // Align: with a ninth bit the data is shift[7:0]
            frame_data <= ninth_en ? shift[7:0] : shift[8:1];
            frame_ninth <= ninth_en ? shift[8] : 1'b0;
          end else
            tick <= tick + 8'h01;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // ump_rx_frame

// File: tb/ump_mproc_rx_props.sv
`timescale 1ns/100ps
`include "ump_defs.vh"
module ump_mproc_rx_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Address decode; a read answer is qualified by pready
  wire rd = pready && !pwrite;
  wire hit = paddr == `UMP_ADDR_MPCTL || (paddr < 12'h014 && !paddr[1:0]);
  property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray slave error");
  property p_unmap; pready && !hit |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map; pready && hit |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_ctl_rsvd;
    rd && paddr == `UMP_ADDR_MPCTL |-> !prdata[31:5] && !prdata[3:1];
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("unassigned control bits not zero");
  property p_buf_w; rd && paddr == `UMP_ADDR_RXBUF |-> !prdata[31:9]; endproperty
  a_buf_w: assert property (p_buf_w)
    else $error("receive buffer too wide");
  // Clearing the mask must drop the level after the register lag
  property p_irq_msk;
    pready && pwrite && paddr == `UMP_ADDR_IRQMSK && !pwdata |-> ##2 !irq;
  endproperty
  a_irq_msk: assert property (p_irq_msk) else $error("masked irq high");
  property p_irq_rst; $rose(presetn) |-> !irq; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule // ump_mproc_rx_props
bind ump_mproc_rx ump_mproc_rx_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

// File: tb/ump_node_tx.sv
`timescale 1ns/100ps
// Another node on the shared line; it drives the line high when idle
module ump_node_tx #(
  parameter BIT_CLKS = 16
) (
  input wire pclk,
  output logic rxd
);
  initial rxd = 1'b1;
  // One frame, LSB first; stp low forces a framing fault
  task send(input logic [7:0] d, input logic n9, input logic h9,
    input logic stp);
    logic [10:0] f;
    f = {stp, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || h9) begin
        rxd <= f[i];
        repeat (BIT_CLKS) @(posedge pclk);
      end
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge pclk);
  endtask
endmodule // ump_node_tx

// File: tb/tb_uart_multiprocessor_address_filter.sv
`timescale 1ns/100ps
`include "ump_defs.vh"
module tb_uart_multiprocessor_address_filter;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, rxd, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #2 pclk = ~pclk;
  // Only the clock enable is tied; everything else is exercised
  ump_mproc_rx DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .irq(irq));
  ump_node_tx u_node (.pclk(pclk), .rxd(rxd));
  task finish_test;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the about 1260 cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high, released after
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Two edges let the registered level follow a write
  task irqis(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task frame(input logic [7:0] d, input logic n9, input logic h9,
    input logic stp);
    u_node.send(d, n9, h9, stp);
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`UMP_ADDR_MPCTL, 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`UMP_ADDR_IRQMSK, 32'h1);
    wr(`UMP_ADDR_MODE, 32'h54);
    // Wait bit alone must not filter while the mode is off
    wr(`UMP_ADDR_MPCTL, 32'h10);
    frame(8'hA5, 1'b0, 1'b0, 1'b1);
    rd(`UMP_ADDR_MPCTL, 32'h10);
    irqis(1'b1);
    rd(`UMP_ADDR_RXBUF, 32'hA5);
    wr(`UMP_ADDR_IRQMSK, 32'h0);
    irqis(1'b0);
    wr(`UMP_ADDR_IRQST, 32'h7);
    wr(`UMP_ADDR_IRQMSK, 32'h1);
    irqis(1'b0);
    // Parity set to odd; in this mode it must be ignored
    wr(`UMP_ADDR_MODE, 32'h57);
    wr(`UMP_ADDR_MPCTL, 32'h11);
    frame(8'h3C, 1'b0, 1'b1, 1'b1);
    frame(8'h66, 1'b0, 1'b1, 1'b0);
    rd(`UMP_ADDR_STAT, 32'h0);
    irqis(1'b0);
    frame(8'h5B, 1'b1, 1'b1, 1'b1);
    rd(`UMP_ADDR_MPCTL, 32'h01);
    rd(`UMP_ADDR_STAT, 32'h1);
    irqis(1'b1);
    rd(`UMP_ADDR_RXBUF, 32'h15B);
    wr(`UMP_ADDR_IRQST, 32'h7);
    frame(8'h3C, 1'b0, 1'b1, 1'b1);
    rd(`UMP_ADDR_STAT, 32'h1);
    // Complete still set: a dropped frame must not flag overrun
    wr(`UMP_ADDR_MPCTL, 32'h11);
    frame(8'hC3, 1'b0, 1'b1, 1'b1);
    rd(`UMP_ADDR_STAT, 32'h1);
    rd(`UMP_ADDR_RXBUF, 32'h03C);
    finish_test;
  end
endmodule // tb_uart_multiprocessor_address_filter
